// ==== ebcs_pkg.sv ====
package ebcs_pkg;
   // Window count: default configuration plus four address windows
   localparam int unsigned NUM_WIN          = 5;
   localparam int unsigned WIN_W            = 3;
   localparam int unsigned SEG_W            = 8;
   localparam int unsigned WAIT_W           = 4;
   // Reset-latched select field encodings
   localparam logic [1:0] SEG_SEL_TWO       = 2'h3;
   localparam logic [1:0] SEG_SEL_EIGHT     = 2'h2;
   localparam logic [1:0] SEG_SEL_NONE      = 2'h1;
   localparam logic [1:0] SEG_SEL_FOUR      = 2'h0;
   localparam logic [1:0] CS_SEL_FIVE       = 2'h3;
   localparam logic [1:0] CS_SEL_NONE       = 2'h2;
   localparam logic [1:0] CS_SEL_TWO        = 2'h1;
   localparam logic [1:0] CS_SEL_THREE      = 2'h0;
   // Segment line masks for each encoding
   localparam logic [7:0] SEG_MASK_TWO      = 8'h03;
   localparam logic [7:0] SEG_MASK_EIGHT    = 8'hFF;
   localparam logic [7:0] SEG_MASK_NONE     = 8'h00;
   localparam logic [7:0] SEG_MASK_FOUR     = 8'h0F;
   // Chip select masks for each encoding
   localparam logic [4:0] CS_MASK_FIVE      = 5'h1F;
   localparam logic [4:0] CS_MASK_NONE      = 5'h00;
   localparam logic [4:0] CS_MASK_TWO       = 5'h03;
   localparam logic [4:0] CS_MASK_THREE     = 5'h07;
   // Reset values of the bus characteristics
   localparam logic [3:0] WAIT_FIELD_RST    = 4'h0;
   localparam logic [3:0] WAIT_MAX          = 4'hF;
   localparam logic [4:0] STRETCH_RST       = 5'h01;
   localparam logic [1:0] CS_MODE_RST       = 2'h0;
   // Chip select mode encoding {write mode bit, read mode bit}
   localparam logic [1:0] CS_MODE_ADDR      = 2'h0;
   localparam logic [1:0] CS_MODE_READ      = 2'h1;
   localparam logic [1:0] CS_MODE_WRITE     = 2'h2;
   localparam logic [1:0] CS_MODE_RW        = 2'h3;
   // Window code for an access with no window chip select
   localparam logic [2:0] WIN_NO_CS         = 3'h7;
endpackage

// ==== ebcs_cyc_if.sv ====
`timescale 1ns/1ps
// Cycle timing handshake between the select logic and the cycle sequencer
interface ebcs_cyc_if;
   logic                          start;
   logic                          stretch;
   logic [ebcs_pkg::WAIT_W-1:0]   wait_field;
   logic                          mux_bus;
   logic                          busy;
   logic                          ale;
   logic                          cmd;
   logic                          done;
   logic                          ale_fall;

   modport ctrl (
      output start,
      output stretch,
      output wait_field,
      output mux_bus,
      input  busy,
      input  ale,
      input  cmd,
      input  done,
      input  ale_fall
   );
   modport seq (
      input  start,
      input  stretch,
      input  wait_field,
      input  mux_bus,
      output busy,
      output ale,
      output cmd,
      output done,
      output ale_fall
   );
endinterface

// ==== ebcs_cycle_seq.sv ====
`timescale 1ns/1ps
// Sequencer of one external bus cycle, counted in half CPU clocks
module ebcs_cycle_seq (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   ebcs_cyc_if.seq   cyc
);
   typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_HOLD, ST_CMD, ST_WAIT} ebcs_seq_e;

   ebcs_seq_e        state_q;
   logic [4:0]       cnt_q;
   logic [3:0]       wait_q;

   ////////////////////////////////////////////////////////////////////////////
   // Phase state machine; half clocks of stretch become whole extra phases
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'h00;
         wait_q  <= 4'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cyc.start) begin
                  state_q <= ST_ALE;
                  cnt_q   <= {4'h0, cyc.stretch};
                  // Wait states are the inverse of the field
                  wait_q  <= ebcs_pkg::WAIT_MAX - cyc.wait_field;
               end
            end
            ST_ALE: begin
               if (cnt_q == 5'h00) begin
                  state_q <= (cyc.mux_bus) ? ST_HOLD : ST_CMD;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            ST_HOLD: begin
               // One address hold cycle; the stretch is paid in the latch phase
               state_q <= ST_CMD;
            end
            ST_CMD: begin
               if (wait_q == 4'h0) begin
                  state_q <= ST_IDLE;
               end else begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               wait_q <= wait_q - 4'h1;
               if (wait_q == 4'h1) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Pin phases decoded from the state
   assign cyc.busy     = (state_q != ST_IDLE);
   assign cyc.ale      = (state_q == ST_ALE);
   assign cyc.ale_fall = (state_q == ST_ALE) && (cnt_q == 5'h00);
   assign cyc.cmd      = (state_q == ST_CMD) || (state_q == ST_WAIT);
   assign cyc.done     = ((state_q == ST_CMD) && (wait_q == 4'h0)) ||
                         ((state_q == ST_WAIT) && (wait_q == 4'h1));
endmodule

// ==== ebcs_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Byte high disable clear makes the upper byte enable pin a bus signal.
// - Byte high disable resets clear for a 16-bit bus, set otherwise.
// - Segment select field picks two, eight, none or four upper address lines.
// - Chip select count field picks five, none, two or three lines.
// - Each chip select is low inside its window, high outside it.
// - Latch strobe fall asserts matching address chip select and drives all others high.
// - Internal accesses leave chip selects unchanged.
// - Access to on-chip extension peripheral deactivates all chip selects.
// - Window without chip select line deactivates all selected lines.
// - Write and read mode bits pick address, read, write or read/write mode.
// - Address mode asserts at latch strobe fall, releases for other area or extension peripheral access.
// - Command modes assert only while matching strobe active; either write strobe.
// - Chip select zero acts as address select on first fetch after reset.
// - Lines pulled high in reset; selected driven after, others released.
// - Pull-ups on selected push-pull lines during hold; open-drain lines float.
// - Stretch bit lengthens latch strobe by half clock; multiplexed address hold is not lengthened.
// - Default configuration stretch resets to one, other windows to zero.
// - Fifteen minus wait field gives wait states; reset gives fifteen.
// - Internal accesses run full speed; external start at slowest settings except stretch in windows 1-4.
// - On 16-bit bus bytes select upper by byte enable, lower by A0.
// - Write pin config turns write pin and byte enable into byte strobes.
module ebcs_top (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Reset strapping
   input  wire logic [1:0]  segment_line_select_in,
   input  wire logic [1:0]  chip_select_count_in,
   input  wire logic        bus16_strap_in,
   input  wire logic        single_chip_in,
   // Software configuration
   input  wire logic        byte_high_disable_wr_in,
   input  wire logic        byte_high_disable_val_in,
   input  wire logic        write_pin_config_in,
   input  wire logic        cfg_wr_in,
   input  wire logic [2:0]  cfg_win_in,
   input  wire logic [1:0]  cfg_cs_mode_in,
   input  wire logic        cfg_stretch_in,
   input  wire logic [3:0]  cfg_wait_field_in,
   input  wire logic        cfg_mux_in,
   input  wire logic [4:0]  cfg_cs_open_drain_in,
   // CPU access request
   input  wire logic        acc_req_in,
   input  wire logic        acc_internal_in,
   input  wire logic        acc_xper_in,
   input  wire logic [2:0]  acc_win_in,
   input  wire logic [23:0] acc_addr_in,
   input  wire logic        acc_write_in,
   input  wire logic        acc_byte_in,
   input  wire logic        hold_acknowledge_in,
   output logic             acc_ready_out,
   output logic             acc_done_out,
   // External pins
   output logic [7:0]       upper_addr_port_out,
   output logic [7:0]       upper_addr_port_oe_out,
   output logic [4:0]       chip_select_port_out,
   output logic [4:0]       chip_select_port_oe_out,
   output logic [4:0]       chip_select_pullup_out,
   output logic             latch_strobe_out,
   output logic             read_strobe_n_out,
   output logic             write_low_strobe_n_out,
   output logic             upper_byte_enable_n_out,
   output logic             upper_byte_enable_oe_out,
   output logic             addr_bit0_out,
   output logic             byte_high_disable_out,
   output logic [3:0]       wait_states_out
);
   ebcs_cyc_if cyc ();

   logic                              cfg_done_q;
   logic [1:0]                        seg_sel_q;
   logic [1:0]                        cs_sel_q;
   logic                              byte_high_disable_q;
   logic [ebcs_pkg::NUM_WIN-1:0][1:0] mode_q;
   logic [ebcs_pkg::NUM_WIN-1:0]      stretch_q;
   logic [ebcs_pkg::NUM_WIN-1:0][3:0] wait_q;
   logic [ebcs_pkg::NUM_WIN-1:0]      mux_q;
   logic [4:0]                        cs_q;
   logic [2:0]                        cur_win_q;
   logic                              cur_write_q;
   logic                              cur_byte_q;
   logic [23:0]                       addr_q;
   logic [4:0]                        cs_mask;
   logic [7:0]                        seg_mask;
   logic [2:0]                        sel_win;

   // Segment line mask for a select code
   function automatic logic [7:0] seg_decode(input logic [1:0] sel);
      case (sel)
         ebcs_pkg::SEG_SEL_TWO:   seg_decode = ebcs_pkg::SEG_MASK_TWO;
         ebcs_pkg::SEG_SEL_EIGHT: seg_decode = ebcs_pkg::SEG_MASK_EIGHT;
         ebcs_pkg::SEG_SEL_NONE:  seg_decode = ebcs_pkg::SEG_MASK_NONE;
         default:                 seg_decode = ebcs_pkg::SEG_MASK_FOUR;
      endcase
   endfunction

   // Chip select mask for a count code
   function automatic logic [4:0] cs_decode(input logic [1:0] sel);
      case (sel)
         ebcs_pkg::CS_SEL_FIVE:  cs_decode = ebcs_pkg::CS_MASK_FIVE;
         ebcs_pkg::CS_SEL_NONE:  cs_decode = ebcs_pkg::CS_MASK_NONE;
         ebcs_pkg::CS_SEL_TWO:   cs_decode = ebcs_pkg::CS_MASK_TWO;
         default:                cs_decode = ebcs_pkg::CS_MASK_THREE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Straps are caught by the first clock after release, never in reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_done_q <= 1'b0;
         seg_sel_q  <= ebcs_pkg::SEG_SEL_NONE;
         cs_sel_q   <= ebcs_pkg::CS_SEL_NONE;
      end else if (!cfg_done_q) begin
         cfg_done_q <= 1'b1;
         seg_sel_q  <= segment_line_select_in;
         cs_sel_q   <= chip_select_count_in;
      end
   end

   assign seg_mask = seg_decode(seg_sel_q);
   assign cs_mask  = cs_decode(cs_sel_q);

   ////////////////////////////////////////////////////////////////////////////
   // Byte high disable: strapped, then software writable
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         byte_high_disable_q <= 1'b1;
      end else if (!cfg_done_q) begin
         byte_high_disable_q <= !bus16_strap_in;
      end else if (byte_high_disable_wr_in) begin
         byte_high_disable_q <= byte_high_disable_val_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-window bus characteristics, slowest after reset except no stretch in windows 1-4
   for (genvar w = 0; w < ebcs_pkg::NUM_WIN; w++) begin : g_win
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mode_q[w]    <= ebcs_pkg::CS_MODE_RST;
            stretch_q[w] <= ebcs_pkg::STRETCH_RST[w];
            wait_q[w]    <= ebcs_pkg::WAIT_FIELD_RST;
            mux_q[w]     <= 1'b1;
         end else if (cfg_wr_in && (cfg_win_in == 3'(w))) begin
            mode_q[w]    <= cfg_cs_mode_in;
            stretch_q[w] <= cfg_stretch_in;
            wait_q[w]    <= cfg_wait_field_in;
            mux_q[w]     <= cfg_mux_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start of an external cycle; internal accesses never reach the bus
   assign sel_win          = (acc_win_in < 3'(ebcs_pkg::NUM_WIN)) ? acc_win_in : 3'h0;
   assign cyc.start        = acc_req_in && !acc_internal_in && !acc_xper_in &&
                             !hold_acknowledge_in && !cyc.busy && cfg_done_q;
   assign cyc.stretch      = stretch_q[sel_win];
   assign cyc.wait_field   = wait_q[sel_win];
   assign cyc.mux_bus      = mux_q[sel_win];
   // Internal and extension accesses finish at once, full speed
   assign acc_ready_out    = cfg_done_q && !cyc.busy && !hold_acknowledge_in;
   assign acc_done_out     = cyc.done ||
                             (acc_req_in && acc_ready_out && (acc_internal_in || acc_xper_in));

   ebcs_cycle_seq u_seq (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .cyc      (cyc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Capture of the running cycle's attributes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur_win_q   <= ebcs_pkg::WIN_NO_CS;
         cur_write_q <= 1'b0;
         cur_byte_q  <= 1'b0;
         addr_q      <= 24'h000000;
      end else if (cyc.start) begin
         // Windows without a chip select line map to the no-select code
         cur_win_q   <= (acc_win_in < 3'(ebcs_pkg::NUM_WIN) && cs_mask[sel_win]) ?
                        acc_win_in : ebcs_pkg::WIN_NO_CS;
         cur_write_q <= acc_write_in;
         cur_byte_q  <= acc_byte_in;
         addr_q      <= acc_addr_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address chip selects: change only at latch strobe fall or extension peripheral access, glitch free
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cs_q <= 5'h1F;
      end else if (acc_req_in && acc_xper_in && acc_ready_out) begin
         cs_q <= 5'h1F;
      end else if (cyc.ale_fall) begin
         // One line low at most; all others high in the same edge
         for (int i = 0; i < ebcs_pkg::NUM_WIN; i++) begin
            cs_q[i] <= !((cur_win_q == 3'(i)) &&
                         (mode_q[i] == ebcs_pkg::CS_MODE_ADDR));
         end
      end
      // Internal accesses fall through with cs_q held
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chip select pins; command modes gated by the matching strobe
   always_comb begin
      for (int i = 0; i < ebcs_pkg::NUM_WIN; i++) begin
         case (mode_q[i])
            ebcs_pkg::CS_MODE_READ:
               chip_select_port_out[i] = !(cyc.cmd && !cur_write_q &&
                                           cur_win_q == 3'(i));
            ebcs_pkg::CS_MODE_WRITE:
               chip_select_port_out[i] = !(cyc.cmd && cur_write_q &&
                                           cur_win_q == 3'(i));
            ebcs_pkg::CS_MODE_RW:
               chip_select_port_out[i] = !(cyc.cmd && cur_win_q == 3'(i));
            default:
               chip_select_port_out[i] = cs_q[i];
         endcase
      end
   end

   // Selected lines driven after reset, released in hold with pull-ups on push-pull lines
   assign chip_select_port_oe_out = (cfg_done_q && !hold_acknowledge_in) ? cs_mask :
                                    5'h00;
   assign chip_select_pullup_out  = !cfg_done_q ? 5'h1F :
                                    hold_acknowledge_in ? (cs_mask & ~cfg_cs_open_drain_in) :
                                    5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Segment address lines and byte controls
   assign upper_addr_port_out    = addr_q[23:16] & seg_mask;
   assign upper_addr_port_oe_out = (cfg_done_q && !hold_acknowledge_in) ? seg_mask : 8'h00;
   assign addr_bit0_out          = addr_q[0];
   assign latch_strobe_out       = cyc.ale;
   assign read_strobe_n_out      = !(cyc.cmd && !cur_write_q);
   assign byte_high_disable_out  = byte_high_disable_q;
   assign wait_states_out        = ebcs_pkg::WAIT_MAX - wait_q[0];

   // Byte strobes or bus byte enable depending on write pin config
   always_comb begin
      if (write_pin_config_in) begin
         write_low_strobe_n_out  = !(cyc.cmd && cur_write_q &&
                                     (!cur_byte_q || !addr_q[0]));
         upper_byte_enable_n_out = !(cyc.cmd && cur_write_q &&
                                     (!cur_byte_q || addr_q[0]));
      end else begin
         write_low_strobe_n_out  = !(cyc.cmd && cur_write_q);
         upper_byte_enable_n_out = !(cyc.busy && (!cur_byte_q || addr_q[0]));
      end
   end

   // Pin released to general I/O when disabled
   assign upper_byte_enable_oe_out = cfg_done_q && !byte_high_disable_q &&
                                     !hold_acknowledge_in;
endmodule

// ==== ebcs_chk.sv ====
`timescale 1ns/1ps
// Port-level timing checks of the chip select block
module ebcs_chk (
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       acc_req_in,
   input wire logic       acc_internal_in,
   input wire logic       acc_xper_in,
   input wire logic       acc_ready_out,
   input wire logic       acc_done_out,
   input wire logic       latch_strobe_out,
   input wire logic       hold_acknowledge_in,
   input wire logic [4:0] cfg_cs_open_drain_in,
   input wire logic [4:0] chip_select_port_out,
   input wire logic [4:0] chip_select_port_oe_out,
   input wire logic [4:0] chip_select_pullup_out,
   input wire logic       byte_high_disable_wr_in,
   input wire logic       byte_high_disable_val_in,
   input wire logic       byte_high_disable_out,
   input wire logic       cfg_wr_in,
   input wire logic [2:0] cfg_win_in,
   input wire logic [3:0] cfg_wait_field_in,
   input wire logic [3:0] wait_states_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Phases of an external cycle
   sequence s_take_ext;
      acc_req_in && acc_ready_out && !acc_internal_in && !acc_xper_in;
   endsequence
   sequence s_latch_first;
      !acc_done_out ##1 (latch_strobe_out && !acc_done_out && !acc_ready_out);
   endsequence
   a_ext_latch_first: assert property (s_take_ext |-> s_latch_first)
      else $error("external cycle did not open with the latch phase");
   // Worst case is stretch, hold phase and fifteen waits
   a_ext_done_bound: assert property (s_take_ext |-> ##[2:22] acc_done_out)
      else $error("external cycle did not end in time");
   a_xper_cs_high: assert property ((acc_req_in && acc_ready_out && acc_xper_in) |->
      ##[1:2] ((chip_select_port_out | ~chip_select_port_oe_out) == 5'h1F))
      else $error("chip selects active after extension peripheral access");
   a_int_cs_keep: assert property ((acc_req_in && acc_ready_out && acc_internal_in
      && !acc_xper_in) |=> $stable(chip_select_port_out))
      else $error("chip selects moved on an internal access");
   a_hold_refuse: assert property (hold_acknowledge_in |-> !acc_ready_out)
      else $error("request accepted during hold");
   a_hold_no_pull: assert property (hold_acknowledge_in [*2] |->
      (chip_select_pullup_out & cfg_cs_open_drain_in) == 5'h00)
      else $error("pull-up on an open-drain line during hold");
   a_bhd_write: assert property (byte_high_disable_wr_in |=>
      byte_high_disable_out == $past(byte_high_disable_val_in))
      else $error("byte high disable not written");
   a_wait_mirror: assert property ((cfg_wr_in && cfg_win_in == 3'h0) |=>
      wait_states_out == 4'hF - $past(cfg_wait_field_in))
      else $error("wait states do not follow the wait field");
endmodule

bind ebcs_top ebcs_chk i_ebcs_chk (.*);

// ==== ebcs_mem_model.sv ====
`timescale 1ns/1ps
// Memory side: a single-enable device only sees lines low while a strobe is active
module ebcs_mem_model (
   input  wire logic       clk_in,
   input  wire logic       seen_clr_in,
   input  wire logic [4:0] chip_select_in,
   input  wire logic       read_strobe_n_in,
   input  wire logic       write_strobe_n_in,
   output logic [4:0]      cs_seen_out
);
   // Gather the lines found low at strobe-active edges
   always_ff @(posedge clk_in) begin
      if (seen_clr_in) begin
         cs_seen_out <= 5'h1F;
      end else if (!read_strobe_n_in || !write_strobe_n_in) begin
         cs_seen_out <= cs_seen_out & chip_select_in;
      end
   end
endmodule

// ==== ebcs_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the chip select and bus cycle block
module tb;
   typedef struct packed {logic [1:0] seg; logic [1:0] cs; logic b16;
      logic [7:0] seg_mask; logic [4:0] cs_mask; logic [4:0] cs_w3;} ebcs_strap_s;
   typedef struct packed {logic [2:0] win; logic [1:0] mode; logic st; logic [3:0] wf;
      logic wr; logic [7:0] n; logic [4:0] seen; logic [4:0] cs_end;} ebcs_row_s;
   // Last strap row leaves five lines and a 16-bit bus for the cycle table
   ebcs_strap_s straps [4] = '{'{2'h2, 2'h2, 1'b0, 8'hFF, 5'h00, 5'h00},
      '{2'h1, 2'h1, 1'b1, 8'h00, 5'h03, 5'h03}, '{2'h0, 2'h0, 1'b0, 8'h0F, 5'h07, 5'h07},
      '{2'h3, 2'h3, 1'b1, 8'h03, 5'h1F, 5'h17}};
   ebcs_row_s rows [6] = '{'{3'h1, ebcs_pkg::CS_MODE_ADDR, 1'b0, 4'hF, 1'b0, 8'h02, 5'h1D, 5'h1D},
      '{3'h2, ebcs_pkg::CS_MODE_READ, 1'b1, 4'hE, 1'b0, 8'h04, 5'h1B, 5'h1F},
      '{3'h3, ebcs_pkg::CS_MODE_READ, 1'b0, 4'hF, 1'b1, 8'h02, 5'h1F, 5'h1F},
      '{3'h4, ebcs_pkg::CS_MODE_WRITE, 1'b0, 4'hD, 1'b1, 8'h04, 5'h0F, 5'h1F},
      '{3'h1, ebcs_pkg::CS_MODE_RW, 1'b0, 4'hF, 1'b1, 8'h02, 5'h1D, 5'h1F},
      '{3'h0, ebcs_pkg::CS_MODE_ADDR, 1'b0, 4'hF, 1'b0, 8'h02, 5'h1E, 5'h1E}};
   logic clk_in = 1'b0, rst_n_in = 1'b0, bus16_strap_in = 1'b0, single_chip_in = 1'b0;
   logic byte_high_disable_wr_in = 1'b0, byte_high_disable_val_in = 1'b0, seen_clr = 1'b1;
   logic write_pin_config_in = 1'b0, cfg_wr_in = 1'b0, cfg_stretch_in = 1'b0, cfg_mux_in = 1'b0;
   logic acc_req_in = 1'b0, acc_internal_in = 1'b0, acc_xper_in = 1'b0, acc_write_in = 1'b0;
   logic acc_byte_in = 1'b0, hold_acknowledge_in = 1'b0;
   logic [1:0] segment_line_select_in = 2'h3, chip_select_count_in = 2'h3, cfg_cs_mode_in = 2'h0;
   logic [2:0] cfg_win_in = 3'h0, acc_win_in = 3'h0;
   logic [3:0] cfg_wait_field_in = 4'h0, wait_states_out;
   logic [4:0] cfg_cs_open_drain_in = 5'h00, chip_select_port_out, chip_select_port_oe_out;
   logic [4:0] chip_select_pullup_out, cs_seen;
   logic [23:0] acc_addr_in = 24'hA51234;
   logic acc_ready_out, acc_done_out, latch_strobe_out, read_strobe_n_out, addr_bit0_out;
   logic write_low_strobe_n_out, upper_byte_enable_n_out, upper_byte_enable_oe_out;
   logic byte_high_disable_out;
   logic [1:0] strb;
   logic [7:0] upper_addr_port_out, upper_addr_port_oe_out;
   int fails = 0, checks = 0, n = 0;
   ////////////////////////////////////////////////////////////////////////////////////////////
   ebcs_top i_ebcs_top (.*);
   // Released lines read high at the memory side
   ebcs_mem_model i_ebcs_mem_model (.clk_in, .seen_clr_in(seen_clr),
      .chip_select_in(chip_select_port_out | ~chip_select_port_oe_out),
      .read_strobe_n_in(read_strobe_n_out),
      .write_strobe_n_in(write_low_strobe_n_out), .cs_seen_out(cs_seen));
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Straps must stand through release, the first edge latches them
   task automatic do_reset(input ebcs_strap_s s);
      @(negedge clk_in);
      rst_n_in = 1'b0;
      {segment_line_select_in, chip_select_count_in, bus16_strap_in} = {s.seg, s.cs, s.b16};
      repeat (12) @(negedge clk_in);
      check("cs_rst", 8'(chip_select_port_out), 8'h1F);
      check("pull_rst", 8'(chip_select_pullup_out), 8'h1F);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      check("bhd", 8'(byte_high_disable_out), 8'(!s.b16));
      check("wait_rst", 8'(wait_states_out), 8'h0F);
   endtask
   // Write one window's bus characteristics
   task automatic cfg(input ebcs_row_s r);
      @(negedge clk_in);
      {cfg_wr_in, cfg_win_in, cfg_cs_mode_in} = {1'b1, r.win, r.mode};
      {cfg_stretch_in, cfg_wait_field_in} = {r.st, r.wf};
      @(negedge clk_in);
      cfg_wr_in = 1'b0;
   endtask
   // One access; n ends as the cycle of done counted from the taking edge
   task automatic access(input logic [2:0] win, input logic intl, input logic xp, input logic wr);
      @(negedge clk_in);
      {seen_clr, strb} = 3'h4;
      n = 0;
      while (acc_ready_out !== 1'b1 && n < 50) begin
         @(negedge clk_in);
         n++;
      end
      {acc_req_in, acc_win_in, acc_internal_in, acc_xper_in, acc_write_in} =
         {1'b1, win, intl, xp, wr};
      @(negedge clk_in);
      {acc_req_in, seen_clr} = 2'b00;
      n = 1;
      while (!intl && !xp && acc_done_out !== 1'b1 && n < 40) begin
         @(negedge clk_in);
         n++;
         strb |= ~{upper_byte_enable_n_out, write_low_strobe_n_out};
      end
      check("done", 8'(n < 40), 8'h01);
      @(negedge clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Strap rows, then the cycle table, then the edge cases
   initial begin
      foreach (straps[i]) begin
         do_reset(straps[i]);
         check("seg_oe", upper_addr_port_oe_out, straps[i].seg_mask);
         check("cs_oe", 8'(chip_select_port_oe_out), 8'(straps[i].cs_mask));
         access(3'h0, 1'b0, 1'b0, 1'b0);
         check("cs_first", 8'(chip_select_port_out & straps[i].cs_mask),
               8'(5'h1E & straps[i].cs_mask));
         access(3'h3, 1'b0, 1'b0, 1'b0);
         check("seg_addr", upper_addr_port_out, 8'hA5 & straps[i].seg_mask);
         check("cs_w3", 8'(chip_select_port_out & straps[i].cs_mask),
               8'(straps[i].cs_w3));
      end
      acc_addr_in = 24'h5A0001;
      foreach (rows[i]) begin
         cfg(rows[i]);
         access(rows[i].win, 1'b0, 1'b0, rows[i].wr);
         check("cycles", 8'(n), rows[i].n);
         check("cs_strobe", 8'(cs_seen), 8'(rows[i].seen));
         check("cs_after", 8'(chip_select_port_out), 8'(rows[i].cs_end));
      end
      {write_pin_config_in, acc_byte_in, acc_addr_in} = {2'h3, 24'h5A0002};
      access(3'h0, 1'b0, 1'b0, 1'b1);
      check("wr_low", 8'(strb), 8'h01);
      {write_pin_config_in, acc_addr_in} = {1'b0, 24'h5A0001};
      access(3'h0, 1'b0, 1'b0, 1'b0);
      check("bhe_odd", 8'(strb), 8'h02);
      check("a0", 8'(addr_bit0_out), 8'h01);
      acc_byte_in = 1'b0;
      access(3'h2, 1'b1, 1'b0, 1'b0);
      check("cs_int", 8'(chip_select_port_out), 8'h1E);
      access(3'h1, 1'b0, 1'b1, 1'b1);
      check("cs_xper", 8'(chip_select_port_out), 8'h1F);
      {byte_high_disable_wr_in, byte_high_disable_val_in} = 2'b11;
      @(negedge clk_in);
      byte_high_disable_wr_in = 1'b0;
      check("bhd_set", 8'(byte_high_disable_out), 8'h01);
      check("bhe_oe", 8'(upper_byte_enable_oe_out), 8'h00);
      {cfg_cs_open_drain_in, hold_acknowledge_in} = {5'h05, 1'b1};
      repeat (2) @(negedge clk_in);
      check("ready_hold", 8'(acc_ready_out), 8'h00);
      check("pull_hold", 8'(chip_select_pullup_out), 8'h1A);
      hold_acknowledge_in = 1'b0;
      access(3'h0, 1'b0, 1'b0, 1'b0);
      check("cs_back", 8'(chip_select_port_out), 8'h1E);
      test_done();
   end
   // 100 MHz clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   // Twenty thousand cycles means a hang
   initial begin
      #200000;
      fails++;
      test_done();
   end
endmodule
